//--- hw/hape_core.sv
// Host adapter command layer emulating one parallel drive over shadow registers
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "hape_map.svh"
module hape_core
  import hape_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Host register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [7:0]             reg_rdata,
  // Transport: outgoing register frame
  output logic                   h2d_valid,
  output hape_h2d_t              h2d_frame,
  // Transport: incoming register frame
  input  wire logic              d2h_valid,
  input  wire hape_d2h_t         d2h_frame,
  // Link: bus reset request
  output logic                   link_bus_reset,
  // Host interrupt and status
  output logic                   host_intr,
  output hape_state_t            state_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  hape_state_t  state;          // Current emulation state
  hape_state_t  next_state;     // Next emulation state
  hape_shadow_t shadow;         // Shadow command and control blocks
  logic         pending;        // Interrupt pending flag
  logic         wr_data;        // Write decodes
  logic         wr_ctrl;
  logic         wr_cmd;
  logic         wr_dev;
  logic         wr_bus_rst;
  logic         rd_status;      // Read decodes
  logic         rd_alt;
  logic         new_soft_reset_bit;       // Written soft reset value
  logic         new_interrupt_disable_bit;       // Written interrupt disable value
  logic         new_dev;        // Written drive select value
  logic         selected;       // Drive 0 selected
  logic         set_busy;       // Busy set request
  logic         clr_pending;    // Pending clear request
  logic         clr_drv_sel;    // Drive select clear request
  logic         send_frame;     // Frame send request
  logic         send_cmd_flag;  // Command flag of that frame
  logic         signal_cond;    // Enabled and pending after this write

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    wr_data    = reg_write && (reg_addr <= `HAPE_OFF_LBA_HIGH);
    wr_dev     = reg_write && (reg_addr == `HAPE_OFF_DEVICE);
    wr_cmd     = reg_write && (reg_addr == `HAPE_OFF_COMMAND);
    wr_ctrl    = reg_write && (reg_addr == `HAPE_OFF_CONTROL);
    wr_bus_rst = reg_write && (reg_addr == `HAPE_OFF_ADAPTER)
                 && reg_wdata[`HAPE_BIT_BUS_RST];
    rd_status  = reg_read && (reg_addr == `HAPE_OFF_STATUS);
    rd_alt     = reg_read && (reg_addr == `HAPE_OFF_CONTROL);
    new_soft_reset_bit   = reg_wdata[`HAPE_BIT_SOFT_RST];
    new_interrupt_disable_bit   = reg_wdata[`HAPE_BIT_INT_DIS];
    new_dev    = reg_wdata[`HAPE_BIT_DRV_SEL];
    selected   = (state != HAPE_OTHER_DRV);
  end

  ////////////////////////////////////////////////////////////////////////
  // Transition logic
  always_comb begin
    next_state    = state;
    set_busy      = 1'b0;
    clr_pending   = 1'b0;
    clr_drv_sel   = 1'b0;
    send_frame    = 1'b0;
    send_cmd_flag = 1'b0;
    signal_cond   = 1'b0;
    case (state)
      // Drive 0 selected, either state
      HAPE_SEL_QUIET, HAPE_SEL_SIGNAL: begin
        if (wr_bus_rst) begin
          // Bus reset from a selected state
          set_busy    = 1'b1;
          clr_pending = 1'b1;
          next_state  = HAPE_SEL_QUIET;
        end else if (wr_ctrl && new_soft_reset_bit) begin
          // Soft reset asserted
          set_busy    = 1'b1;
          clr_pending = 1'b1;
          send_frame  = 1'b1;
          next_state  = HAPE_SEL_QUIET;
        end else if (wr_ctrl) begin
          // Soft reset low: frame always sent, the optional skip is not taken
          send_frame  = 1'b1;
          signal_cond = !new_interrupt_disable_bit && pending;
          next_state  = signal_cond ? HAPE_SEL_SIGNAL : HAPE_SEL_QUIET;
        end else if (wr_cmd) begin
          // Command issue
          set_busy      = 1'b1;
          clr_pending   = 1'b1;
          send_frame    = 1'b1;
          send_cmd_flag = 1'b1;
          next_state    = HAPE_SEL_QUIET;
        end else if (wr_dev && new_dev) begin
          // Other drive selected
          next_state = HAPE_OTHER_DRV;
        end else if ((state == HAPE_SEL_SIGNAL) && rd_status) begin
          // Status read acknowledges the interrupt
          clr_pending = 1'b1;
          next_state  = HAPE_SEL_QUIET;
        end else if ((state == HAPE_SEL_QUIET) && d2h_valid) begin
          // Incoming frame may raise the interrupt
          if (d2h_frame.pending && !shadow.control[`HAPE_BIT_INT_DIS]) begin
            next_state = HAPE_SEL_SIGNAL;
          end
        end
        // Other writes and reads keep the state
      end
      // Drive 1 selected
      HAPE_OTHER_DRV: begin
        if (wr_bus_rst) begin
          // Bus reset also deselects drive 1
          set_busy    = 1'b1;
          clr_pending = 1'b1;
          clr_drv_sel = 1'b1;
          next_state  = HAPE_SEL_QUIET;
        end else if (wr_ctrl && new_soft_reset_bit) begin
          // Soft reset returns to drive 0
          set_busy    = 1'b1;
          clr_pending = 1'b1;
          clr_drv_sel = 1'b1;
          send_frame  = 1'b1;
          next_state  = HAPE_SEL_QUIET;
        end else if (wr_ctrl) begin
          // Control frame, stay deselected
          send_frame = 1'b1;
        end else if (wr_cmd && (reg_wdata == `HAPE_CMD_DIAG)) begin
          // Diagnostic reaches drive 0
          set_busy      = 1'b1;
          clr_pending   = 1'b1;
          clr_drv_sel   = 1'b1;
          send_frame    = 1'b1;
          send_cmd_flag = 1'b1;
          next_state    = HAPE_SEL_QUIET;
        end else if (wr_dev && !new_dev) begin
          // Reselect drive 0
          signal_cond = !shadow.control[`HAPE_BIT_INT_DIS] && pending;
          next_state  = signal_cond ? HAPE_SEL_SIGNAL : HAPE_SEL_QUIET;
        end
        // Non-diagnostic commands and other traffic stay here
      end
      default: begin
        next_state = HAPE_SEL_QUIET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= HAPE_SEL_QUIET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending flag; a frame arriving with a clear wins over the clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pending <= 1'b0;
    end else if (d2h_valid) begin
      pending <= d2h_frame.pending;
    end else if (clr_pending) begin
      pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shadow registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shadow         <= '0;
      shadow.status  <= `HAPE_RST_STATUS;
      shadow.control <= `HAPE_RST_CONTROL;
      shadow.device  <= `HAPE_RST_DEVICE;
    end else begin
      // Incoming frame replaces the command block in any state
      if (d2h_valid) begin
        shadow <= d2h_frame.shadow;
        shadow.control <= shadow.control;
      end
      // Host writes to the command and control blocks
      if (wr_data) begin
        case (reg_addr)
          `HAPE_OFF_DATA:     shadow.data     <= reg_wdata;
          `HAPE_OFF_FEATURE:  shadow.feature  <= reg_wdata;
          `HAPE_OFF_COUNT:    shadow.count    <= reg_wdata;
          `HAPE_OFF_LBA_LOW:  shadow.lba_low  <= reg_wdata;
          `HAPE_OFF_LBA_MID:  shadow.lba_mid  <= reg_wdata;
          default:            shadow.lba_high <= reg_wdata;
        endcase
      end
      if (wr_dev) begin
        shadow.device <= reg_wdata;
      end
      if (wr_ctrl) begin
        shadow.control <= reg_wdata;
      end
      // Command code is held in the status slot of the shadow registers
      if (wr_cmd && send_cmd_flag) begin
        shadow.status <= reg_wdata;
      end
      if (set_busy) begin
        shadow.status[`HAPE_BIT_BUSY] <= 1'b1;
      end
      if (clr_drv_sel) begin
        shadow.device[`HAPE_BIT_DRV_SEL] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outgoing frame request, one-cycle pulse with written values merged
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      h2d_valid <= 1'b0;
      h2d_frame <= '0;
    end else begin
      h2d_valid <= send_frame;
      if (send_frame) begin
        h2d_frame.command_flag <= send_cmd_flag;
        h2d_frame.shadow       <= shadow;
        if (wr_ctrl) begin
          h2d_frame.shadow.control <= reg_wdata;
        end
        if (wr_cmd) begin
          h2d_frame.shadow.status <= reg_wdata;    // Command code carried here
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus reset request pulse toward the link
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_bus_reset <= 1'b0;
    end else begin
      link_bus_reset <= wr_bus_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (!selected && (rd_status || rd_alt)) begin
        reg_rdata <= `HAPE_NOTSEL_READ;
      end else begin
        case (reg_addr)
          `HAPE_OFF_DATA:     reg_rdata <= shadow.data;
          `HAPE_OFF_FEATURE:  reg_rdata <= shadow.feature;
          `HAPE_OFF_COUNT:    reg_rdata <= shadow.count;
          `HAPE_OFF_LBA_LOW:  reg_rdata <= shadow.lba_low;
          `HAPE_OFF_LBA_MID:  reg_rdata <= shadow.lba_mid;
          `HAPE_OFF_LBA_HIGH: reg_rdata <= shadow.lba_high;
          `HAPE_OFF_DEVICE:   reg_rdata <= shadow.device;
          `HAPE_OFF_STATUS:   reg_rdata <= shadow.status;
          `HAPE_OFF_CONTROL:  reg_rdata <= shadow.status;
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output and state view
  hape_intr_gate u_intr (
    .clock     (clock),
    .reset_n   (reset_n),
    .state     (state),
    .host_intr (host_intr)
  );

  assign state_out = state;

endmodule : hape_core

//--- pkg/hape_map.svh
// Register offsets, field positions, reset values and codes for the shadow register emulation
`ifndef HAPE_MAP_SVH
`define HAPE_MAP_SVH

// Shadow command block offsets (register index on the plain port)
`define HAPE_OFF_DATA      4'h0
`define HAPE_OFF_FEATURE   4'h1
`define HAPE_OFF_COUNT     4'h2
`define HAPE_OFF_LBA_LOW   4'h3
`define HAPE_OFF_LBA_MID   4'h4
`define HAPE_OFF_LBA_HIGH  4'h5
`define HAPE_OFF_DEVICE    4'h6
`define HAPE_OFF_COMMAND   4'h7
// Read of the command offset returns status
`define HAPE_OFF_STATUS    4'h7
// Control block: device control on write, alternate status on read
`define HAPE_OFF_CONTROL   4'hE
// Adapter control: write bit 0 to request a bus reset
`define HAPE_OFF_ADAPTER   4'hF

// Field positions
`define HAPE_BIT_BUSY      7
`define HAPE_BIT_DRV_SEL   4
`define HAPE_BIT_SOFT_RST  2
`define HAPE_BIT_INT_DIS   1
`define HAPE_BIT_BUS_RST   0

// Reset values and codes
`define HAPE_RST_STATUS    8'h00
`define HAPE_RST_CONTROL   8'h00
`define HAPE_RST_DEVICE    8'h00
`define HAPE_NOTSEL_READ   8'h00
`define HAPE_CMD_DIAG      8'h90

`endif

//--- pkg/hape_pkg.sv
// Types shared by the shadow register emulation
package hape_pkg;

  // Adapter emulation states, one-hot
  typedef enum logic [2:0] {
    HAPE_SEL_QUIET  = 3'b001,
    HAPE_SEL_SIGNAL = 3'b010,
    HAPE_OTHER_DRV  = 3'b100
  } hape_state_t;

  // Shadow command and control block contents
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] device;
    logic [7:0] status;
    logic [7:0] control;
  } hape_shadow_t;

  // Host-to-device register frame request toward transport
  typedef struct packed {
    logic         command_flag;
    hape_shadow_t shadow;
  } hape_h2d_t;

  // Device-to-host register frame from transport
  typedef struct packed {
    logic         pending;
    hape_shadow_t shadow;
  } hape_d2h_t;

endpackage : hape_pkg

//--- hw/hape_intr_gate.sv
// Interrupt output gate for the selected-signalling state
`timescale 1ns/1ns
module hape_intr_gate
  import hape_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // State in
  input  wire hape_state_t state,
  // Host interrupt line
  output logic             host_intr
);

  // Registered so the line never glitches on state decode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_intr <= 1'b0;
    end else begin
      host_intr <= (state == HAPE_SEL_SIGNAL);
    end
  end

endmodule : hape_intr_gate

//--- dv/hape_core_properties.sv
// Concurrent checks on the shadow register emulation ports
`timescale 1ns/1ns
`include "hape_map.svh"
module hape_core_checker
  import hape_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset_n,
  // Host register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [7:0]        reg_rdata,
  // Transport and link
  input wire logic              h2d_valid,
  input wire hape_h2d_t         h2d_frame,
  input wire logic              d2h_valid,
  input wire logic              link_bus_reset,
  // Host side
  input wire logic              host_intr,
  input wire hape_state_t       state_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // Request decodes
  logic sig, oth, wr_cmd, wr_ctl, wr_dev, rd_st;
  assign sig    = state_out == HAPE_SEL_SIGNAL;
  assign oth    = state_out == HAPE_OTHER_DRV;
  assign wr_cmd = reg_write && !d2h_valid && reg_addr == `HAPE_OFF_COMMAND;
  assign wr_ctl = reg_write && !d2h_valid && reg_addr == `HAPE_OFF_CONTROL;
  assign wr_dev = reg_write && !d2h_valid && reg_addr == `HAPE_OFF_DEVICE;
  assign rd_st  = reg_read && (reg_addr == `HAPE_OFF_STATUS || reg_addr == `HAPE_OFF_CONTROL);
  ////////////////////////////////////////////////////////////////
  // Properties
  property p_on; sig |=> host_intr; endproperty
  a_on: assert property (p_on) else $error("intr low while signalling");
  property p_off; !sig |=> !host_intr; endproperty
  a_off: assert property (p_off) else $error("intr high outside signalling");
  property p_cmd; !oth && wr_cmd |=> h2d_valid && h2d_frame.command_flag && state_out == HAPE_SEL_QUIET; endproperty
  a_cmd: assert property (p_cmd) else $error("command write mishandled");
  property p_soft_reset_bit; !oth && wr_ctl && reg_wdata[2] |=> h2d_valid && !h2d_frame.command_flag ##1 !host_intr; endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset mishandled");
  property p_ctl; wr_ctl && !reg_wdata[2] |=> h2d_valid && !h2d_frame.command_flag && $stable(oth); endproperty
  a_ctl: assert property (p_ctl) else $error("control frame missing");
  property p_bus; reg_write && reg_addr == `HAPE_OFF_ADAPTER && reg_wdata[0] |=> link_bus_reset ##1 !host_intr; endproperty
  a_bus: assert property (p_bus) else $error("bus reset mishandled");
  property p_dev; !oth && wr_dev && reg_wdata[4] |=> oth && !h2d_valid; endproperty
  a_dev: assert property (p_dev) else $error("select of drive 1 missed");
  property p_plain; reg_write && !d2h_valid && reg_addr < `HAPE_OFF_DEVICE |=> !h2d_valid && $stable(state_out); endproperty
  a_plain: assert property (p_plain) else $error("plain write changed state");
  property p_clr; sig && reg_read && !d2h_valid && reg_addr == `HAPE_OFF_STATUS |=> !sig ##1 !host_intr; endproperty
  a_clr: assert property (p_clr) else $error("status read kept signalling");
  property p_zero; oth && rd_st |=> reg_rdata == 8'h00 && oth; endproperty
  a_zero: assert property (p_zero) else $error("status not zero for drive 1");
  property p_nodiag; oth && wr_cmd && reg_wdata != `HAPE_CMD_DIAG |=> !h2d_valid && oth; endproperty
  a_nodiag: assert property (p_nodiag) else $error("drive 1 command acted on");
  property p_diag; oth && wr_cmd && reg_wdata == `HAPE_CMD_DIAG |=> h2d_valid && h2d_frame.command_flag && !oth; endproperty
  a_diag: assert property (p_diag) else $error("diagnostic mishandled");
  property p_back; oth && wr_dev && !reg_wdata[4] |=> !oth && !h2d_valid; endproperty
  a_back: assert property (p_back) else $error("drive 0 select missed");
endmodule : hape_core_checker
bind hape_core hape_core_checker #(.ADDR_W(ADDR_W)) hape_core_checker_i (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .h2d_valid(h2d_valid),
  .h2d_frame(h2d_frame), .d2h_valid(d2h_valid), .link_bus_reset(link_bus_reset),
  .host_intr(host_intr), .state_out(state_out));

//--- dv/hape_xport_model.sv
// Behavioural transport layer on the far side of the frame ports
`timescale 1ns/1ns
module hape_xport_model
  import hape_pkg::*;
(
  // Clock
  input  wire logic      clock,
  // Frames from the adapter
  input  wire logic      h2d_valid,
  input  wire hape_h2d_t h2d_frame,
  // Frames toward the adapter
  output logic           d2h_valid,
  output hape_d2h_t      d2h_frame
);
  int frame_count; // Frames taken from the adapter
  initial begin
    d2h_valid   = 1'b0;
    d2h_frame   = '0;
    frame_count = 0;
  end
  // Count every outgoing frame
  always @(posedge clock) begin
    if (h2d_valid === 1'b1) begin
      frame_count++;
    end
  end
  // Deliver one frame after a gap; the idle lines then show the inverse
  task automatic send(input int gap, input logic pend, input hape_shadow_t sh);
    repeat (gap + 1) @(posedge clock);
    d2h_valid <= 1'b1;
    d2h_frame <= {pend, sh};
    @(posedge clock);
    d2h_valid <= 1'b0;
    d2h_frame <= ~{pend, sh};
    #1;
  endtask : send
endmodule : hape_xport_model

//--- dv/tb_hape_core.sv
// Self-checking bench for the shadow register emulation
`timescale 1ns/1ns
module tb_hape_core
  import hape_pkg::*;
;
  logic         clock, reset_n, reg_write, reg_read, h2d_valid, d2h_valid, link_bus_reset, host_intr;
  logic [3:0]   reg_addr;
  logic [7:0]   reg_wdata, reg_rdata;
  hape_h2d_t    h2d_frame;
  hape_d2h_t    d2h_frame;
  hape_state_t  state_out;
  int           err_total, check_count, cyc, nfr;
  hape_shadow_t sh; // Incoming frame contents, drive select clear
  hape_core hape_core_i (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .h2d_valid(h2d_valid),
    .h2d_frame(h2d_frame), .d2h_valid(d2h_valid), .d2h_frame(d2h_frame),
    .link_bus_reset(link_bus_reset), .host_intr(host_intr), .state_out(state_out));
  hape_xport_model hape_xport_model_i (.clock(clock), .h2d_valid(h2d_valid), .h2d_frame(h2d_frame),
    .d2h_valid(d2h_valid), .d2h_frame(d2h_frame));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Write, then compare frame valid and command flag
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] ef);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
    chk({h2d_valid, h2d_valid & h2d_frame.command_flag}, ef);
    nfr += ef[1];
  endtask : wr
  // Read, then compare the masked data
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rd
  // Interrupt line one edge after the state
  task automatic intr(input logic e);
    @(posedge clock);
    #1;
    chk(host_intr, e);
  endtask : intr
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_basic();
    chk(state_out, HAPE_SEL_QUIET);
    rd(4'h6, 8'hFF, 8'h00);
    wr(4'h7, 8'h20, 2'b11);
    chk(h2d_frame.shadow.status, 8'h20);
    rd(4'h7, 8'h80, 8'h80);
    wr(4'h3, 8'hA5, 2'b00);
    wr(4'hF, 8'h00, 2'b00);
    chk({link_bus_reset, state_out}, {1'b0, HAPE_SEL_QUIET});
    rd(4'h3, 8'hFF, 8'hA5);
    $display("t_basic done");
  endtask : t_basic
  task automatic t_intr();
    hape_xport_model_i.send(0, 1'b1, sh);
    chk(state_out, HAPE_SEL_SIGNAL);
    intr(1'b1);
    rd(4'h4, 8'hFF, 8'h55);
    rd(4'hE, 8'hFF, 8'h50);
    chk(state_out, HAPE_SEL_SIGNAL);
    wr(4'h1, 8'h0F, 2'b00);
    hape_xport_model_i.send(3, 1'b1, sh);
    chk(state_out, HAPE_SEL_SIGNAL);
    rd(4'h7, 8'hFF, 8'h50);
    chk(state_out, HAPE_SEL_QUIET);
    intr(1'b0);
    wr(4'hE, 8'h00, 2'b10);
    chk({h2d_frame.shadow.feature, h2d_frame.shadow.control}, 16'h2200);
    chk(state_out, HAPE_SEL_QUIET);
    $display("t_intr done");
  endtask : t_intr
  task automatic t_mask();
    wr(4'hE, 8'h02, 2'b10);
    hape_xport_model_i.send(0, 1'b1, sh);
    chk(state_out, HAPE_SEL_QUIET);
    intr(1'b0);
    wr(4'hE, 8'h00, 2'b10);
    chk(state_out, HAPE_SEL_SIGNAL);
    wr(4'hE, 8'h04, 2'b10);
    chk(state_out, HAPE_SEL_QUIET);
    rd(4'h7, 8'h80, 8'h80);
    wr(4'hE, 8'h00, 2'b10);
    chk(state_out, HAPE_SEL_QUIET);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_other();
    hape_xport_model_i.send(1, 1'b1, sh);
    wr(4'h6, 8'h10, 2'b00);
    chk(state_out, HAPE_OTHER_DRV);
    intr(1'b0);
    rd(4'h7, 8'hFF, 8'h00);
    rd(4'hE, 8'hFF, 8'h00);
    rd(4'h6, 8'hFF, 8'h10);
    wr(4'h7, 8'h20, 2'b00);
    wr(4'h2, 8'h07, 2'b00);
    wr(4'hE, 8'h00, 2'b10);
    chk(state_out, HAPE_OTHER_DRV);
    wr(4'h6, 8'h00, 2'b00);
    chk(state_out, HAPE_SEL_SIGNAL);
    $display("t_other done");
  endtask : t_other
  task automatic t_resets();
    wr(4'h6, 8'h10, 2'b00);
    hape_xport_model_i.send(0, 1'b0, sh);
    rd(4'h4, 8'hFF, 8'h55);
    wr(4'h7, 8'h90, 2'b11);
    chk(state_out, HAPE_SEL_QUIET);
    rd(4'h6, 8'h10, 8'h00);
    rd(4'h7, 8'h80, 8'h80);
    wr(4'h6, 8'h10, 2'b00);
    wr(4'hE, 8'h04, 2'b10);
    chk(state_out, HAPE_SEL_QUIET);
    rd(4'h6, 8'h10, 8'h00);
    wr(4'h6, 8'h10, 2'b00);
    wr(4'hF, 8'h01, 2'b00);
    chk({link_bus_reset, state_out}, {1'b1, HAPE_SEL_QUIET});
    rd(4'h6, 8'h10, 8'h00);
    hape_xport_model_i.send(0, 1'b1, sh);
    wr(4'hF, 8'h01, 2'b00);
    chk({link_bus_reset, state_out}, {1'b1, HAPE_SEL_QUIET});
    rd(4'h7, 8'h80, 8'h80);
    wr(4'hE, 8'h00, 2'b10);
    chk(state_out, HAPE_SEL_QUIET);
    $display("t_resets done");
  endtask : t_resets
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n   = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    sh        = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h40, 8'h50, 8'h00};
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_basic();
    t_intr();
    t_mask();
    t_other();
    t_resets();
    repeat (2) @(posedge clock);
    chk(hape_xport_model_i.frame_count, nfr);
    wrap_up();
  end
endmodule : tb_hape_core
